// ### hdl/csq_status.sv
// core status sideband: quiesce handshake, reservation, time base, sync hold, valid
// assumes core-side control from logic on clk; pins from the system pass two flops
//
// Behaviour
// - request quiesce so snooped bus traffic ends or pauses
// - stop snooping once quiescent
// - request may rise any cycle; held throughout the quiescent state
// - with acknowledge low, never go quiescent and keep snooping
// - reservation output mirrors the reservation coherency bit
// - reservation changes on clock edges; load-and-reserve sets it
// - time-base enable gates counting; may change on any cycle
// - sync hold stops execution after a sync instruction until negated
// - valid indicator rises on third cycle after hard reset release
// - valid does not gate the associated outputs; always driven
// - valid never falls again after rising in normal operation
`include "csq_regs.svh"
module csq_status #(
  parameter int TB_WIDTH = 64
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  quiesceWant,
  input  wire logic                  quiesceAck,
  input  wire logic                  loadReserve,
  input  wire logic                  resvClear,
  input  wire logic                  timeBaseEn,
  input  wire logic                  syncDone,
  input  wire logic                  syncHold,
  input  wire logic                  busReqIn,
  input  wire logic                  iBrk2In,
  input  wire logic                  dBrk2In,
  output logic                       quiesceReq,
  output logic                       snoopEn,
  output logic                       quiescent,
  output logic                       reservation,
  output logic [TB_WIDTH-1:0]        timeBase,
  output logic                       execStall,
  output logic                       outputsValid,
  output logic                       bus_request_out,
  output logic                       instr_breakpoint2_hit_out,
  output logic                       data_breakpoint2_hit_out
);
  import csq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage read only by the second
  logic [3:0] pinMeta_r;
  logic [3:0] pinSync_r;
  logic       ackS;
  logic       tbenS;
  logic       holdS;
  logic       wantS;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_r <= 4'h0;
      pinSync_r <= 4'h0;
    end else begin
      pinMeta_r <= {quiesceWant, syncHold, timeBaseEn, quiesceAck};
      pinSync_r <= pinMeta_r;
    end
  end
  assign ackS  = pinSync_r[0];
  assign tbenS = pinSync_r[1];
  assign holdS = pinSync_r[2];
  assign wantS = pinSync_r[3];

  ////////////////////////////////////////////////////////////////////////////
  // quiesce handshake
  csq_qstate_t qState_r;
  csq_qstate_t qState_nxt;
  always_comb begin
    qState_nxt = qState_r;
    unique case (qState_r)
      CSQ_RUN: begin
        if (wantS) begin
          qState_nxt = CSQ_REQ;
        end
      end
      CSQ_REQ: begin
        if (!wantS) begin
          qState_nxt = CSQ_RUN;
        end else if (ackS) begin
          qState_nxt = CSQ_QUIET;
        end
      end
      CSQ_QUIET: begin
        if (!wantS) begin
          qState_nxt = CSQ_WAKE;
        end
      end
      CSQ_WAKE: begin
        qState_nxt = CSQ_RUN;
      end
      default: qState_nxt = CSQ_RUN;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      qState_r <= CSQ_RUN;
    end else begin
      qState_r <= qState_nxt;
    end
  end

  logic quiesceReq_nxt;
  logic snoopEn_nxt;
  logic quiescent_nxt;
  always_comb begin
    quiesceReq_nxt = (qState_nxt == CSQ_REQ) || (qState_nxt == CSQ_QUIET);
    snoopEn_nxt    = (qState_nxt != CSQ_QUIET);
    quiescent_nxt  = (qState_nxt == CSQ_QUIET);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quiesceReq <= 1'b0;
      snoopEn    <= 1'b1;
      quiescent  <= 1'b0;
    end else begin
      quiesceReq <= quiesceReq_nxt;
      snoopEn    <= snoopEn_nxt;
      quiescent  <= quiescent_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reservation and time base
  logic                resv_nxt;
  logic [TB_WIDTH-1:0] timeBase_nxt;
  always_comb begin
    resv_nxt = reservation;
    if (loadReserve) begin
      resv_nxt = 1'b1;
    end else if (resvClear) begin
      resv_nxt = 1'b0;
    end
    timeBase_nxt = tbenS ? timeBase + TB_WIDTH'(1) : timeBase;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reservation <= `CSQ_RESV_RESET;
      timeBase    <= TB_WIDTH'(`CSQ_TB_RESET);
    end else begin
      reservation <= resv_nxt;
      timeBase    <= timeBase_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync hold
  csq_sstate_t sState_r;
  csq_sstate_t sState_nxt;
  logic        execStall_nxt;
  always_comb begin
    sState_nxt = sState_r;
    unique case (sState_r)
      CSQ_EXEC: begin
        if (syncDone && holdS) begin
          sState_nxt = CSQ_SYNCHLD;
        end
      end
      CSQ_SYNCHLD: begin
        if (!holdS) begin
          sState_nxt = CSQ_EXEC;
        end
      end
      default: sState_nxt = CSQ_EXEC;
    endcase
    execStall_nxt = (sState_nxt == CSQ_SYNCHLD);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sState_r  <= CSQ_EXEC;
      execStall <= 1'b0;
    end else begin
      sState_r  <= sState_nxt;
      execStall <= execStall_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output valid and passthrough status outputs
  logic [1:0] validCnt_r;
  logic [1:0] validCnt_nxt;
  logic       valid_nxt;
  always_comb begin
    validCnt_nxt = validCnt_r;
    valid_nxt    = outputsValid;
    if (validCnt_r != `CSQ_VALID_DELAY - 2'd1) begin
      validCnt_nxt = validCnt_r + 2'd1;
    end else begin
      valid_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      validCnt_r                <= 2'd0;
      outputsValid              <= 1'b0;
      bus_request_out           <= 1'b0;
      instr_breakpoint2_hit_out <= 1'b0;
      data_breakpoint2_hit_out  <= 1'b0;
    end else begin
      validCnt_r                <= validCnt_nxt;
      outputsValid              <= valid_nxt;
      bus_request_out           <= busReqIn;
      instr_breakpoint2_hit_out <= iBrk2In;
      data_breakpoint2_hit_out  <= dBrk2In;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_NO_QUIET_NO_ACK: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(quiescent) |-> $past(ackS)) else $error("quiet entered without ack");
  AST_QUIET_NO_SNOOP: assert property (@(posedge clk) disable iff (!rst_b)
    quiescent |-> !snoopEn) else $error("snooping while quiescent");
  AST_REQ_HELD: assert property (@(posedge clk) disable iff (!rst_b)
    quiescent |-> quiesceReq) else $error("request dropped while quiescent");
  AST_REQ_RISE: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(wantS) && qState_r == CSQ_RUN |=> quiesceReq) else $error("request not raised");
  AST_WAKE: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(quiescent) |-> !quiesceReq && snoopEn) else $error("bad wake");
  AST_RESV_SET: assert property (@(posedge clk) disable iff (!rst_b)
    loadReserve |=> reservation) else $error("reservation not set");
  AST_TB_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !tbenS |=> $stable(timeBase)) else $error("time base moved while disabled");
  AST_TB_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    tbenS |=> timeBase == $past(timeBase) + TB_WIDTH'(1)) else $error("time base stuck");
  AST_SYNC_STALL: assert property (@(posedge clk) disable iff (!rst_b)
    syncDone && holdS && !execStall |=> execStall) else $error("no stall after sync");
  AST_SYNC_GO: assert property (@(posedge clk) disable iff (!rst_b)
    execStall && !holdS |=> !execStall) else $error("stall not released");
  AST_VALID_TIME: assert property (@(posedge clk)
    $rose(rst_b) |-> !outputsValid ##1 !outputsValid ##1 !outputsValid ##1 outputsValid)
    else $error("valid not on third cycle");
  AST_VALID_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
    outputsValid |=> outputsValid) else $error("valid fell");

  AST_ABORT: assert property (@(posedge clk) disable iff (!rst_b)
    qState_r == CSQ_REQ && !wantS |=> !quiesceReq && !quiescent)
    else $error("request not withdrawn");
  AST_NO_ACK_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
    qState_r == CSQ_REQ && wantS && !ackS |=> quiesceReq && !quiescent && snoopEn)
    else $error("left request without ack");
  AST_SNOOP_AWAKE: assert property (@(posedge clk) disable iff (!rst_b)
    !quiescent |-> snoopEn)
    else $error("snooping stopped while awake");
  AST_WAKE_DROP: assert property (@(posedge clk) disable iff (!rst_b)
    quiescent && !wantS |=> !quiescent && !quiesceReq && snoopEn)
    else $error("quiet state not left");
  AST_QUIET_STAY: assert property (@(posedge clk) disable iff (!rst_b)
    quiescent && wantS |=> quiescent && quiesceReq)
    else $error("quiet state left early");

  AST_RESV_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    resvClear && !loadReserve |=> !reservation)
    else $error("reservation not cleared");
  AST_RESV_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    !loadReserve && !resvClear |=> $stable(reservation))
    else $error("reservation moved by itself");

  AST_SYNC_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    execStall && holdS |=> execStall)
    else $error("stall released under hold");
  AST_NO_STALL: assert property (@(posedge clk) disable iff (!rst_b)
    !execStall && !(syncDone && holdS) |=> !execStall)
    else $error("stall without sync");

  AST_PASS: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> {bus_request_out, instr_breakpoint2_hit_out, data_breakpoint2_hit_out}
             == $past({busReqIn, iBrk2In, dBrk2In}))
    else $error("status outputs not driven");

  // helper: edges since reset release, saturating at seven
  logic [2:0] relAge_r;
  logic [2:0] relAge_nxt;
  always_comb begin
    relAge_nxt = (relAge_r == 3'h7) ? relAge_r : relAge_r + 3'h1;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      relAge_r <= 3'h0;
    end else begin
      relAge_r <= relAge_nxt;
    end
  end
  AST_VALID_AGE: assert property (@(posedge clk) disable iff (!rst_b)
    outputsValid == (relAge_r >= 3'(`CSQ_VALID_DELAY)))
    else $error("valid not tied to release age");

  COV_QUIET: cover property (@(posedge clk) disable iff (!rst_b) $rose(quiescent));
  COV_ABORT: cover property (@(posedge clk) disable iff (!rst_b)
    qState_r == CSQ_REQ && !wantS);
  COV_STALL: cover property (@(posedge clk) disable iff (!rst_b) $fell(execStall));
  COV_RESV: cover property (@(posedge clk) disable iff (!rst_b) $rose(reservation));
  COV_WAKE: cover property (@(posedge clk) disable iff (!rst_b) qState_r == CSQ_WAKE);
endmodule

// ### hdl/csq_regs.svh
// timing counts and reset values of the core status sideband
// assumes inclusion by the principal design file only
`ifndef CSQ_REGS_SVH
`define CSQ_REGS_SVH
`define CSQ_VALID_DELAY   2'd3
`define CSQ_TB_RESET      64'h0
`define CSQ_RESV_RESET    1'b0
`endif

// ### hdl/csq_pkg.sv
// types of the core status sideband
// assumes no other package
package csq_pkg;
  typedef enum logic [3:0] {
    CSQ_RUN     = 4'b0001,
    CSQ_REQ     = 4'b0010,
    CSQ_QUIET   = 4'b0100,
    CSQ_WAKE    = 4'b1000
  } csq_qstate_t;
  typedef enum logic [1:0] {
    CSQ_EXEC    = 2'b01,
    CSQ_SYNCHLD = 2'b10
  } csq_sstate_t;
endpackage

// ### verif/csq_sys_model.sv
// system-side quiesce acknowledge model
// assumes quiesceReq from the design on clk; ackAllowed from the bench
module csq_sys_model #(
  parameter int ACK_WAIT = 2
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic quiesceReq,
  input  wire logic ackAllowed,
  output logic      quiesceAck
);
  timeunit 1ns;
  timeprecision 1ps;
  int waitCnt;
  ////////////////////////////////////////////////////////////////////////////////
  // ack only while request stands and traffic stopped
  // dropping ackAllowed withdraws ack, still held a whole cycle at least
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt <= 0;
      quiesceAck <= 1'b0;
    end else if (quiesceReq && ackAllowed) begin
      waitCnt <= waitCnt + 1;
      if (waitCnt >= ACK_WAIT) quiesceAck <= 1'b1;
    end else begin
      waitCnt <= 0;
      quiesceAck <= 1'b0;
    end
  end
endmodule

// ### verif/core_status_quiesce_signals_test.sv
// bench for the core status sideband
// assumes csq_status and csq_sys_model compiled before it
module core_status_quiesce_signals_test;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
  logic clk, rst_b, quiesceWant, loadReserve, resvClear, timeBaseEn, syncDone;
  logic syncHold, busReqIn, iBrk2In, dBrk2In, ackAllowed, quiesceAck, quiesceReq;
  logic snoopEn, quiescent, reservation, execStall, outputsValid;
  logic busOut, iOut, dOut;
  logic [63:0] timeBase;
  int num_errors, comparisons;
  ////////////////////////////////////////////////////////////////////////////////
  csq_status #(.TB_WIDTH(64)) dut_u (.clk(clk), .rst_b(rst_b), .quiesceWant(quiesceWant),
    .quiesceAck(quiesceAck), .loadReserve(loadReserve), .resvClear(resvClear),
    .timeBaseEn(timeBaseEn), .syncDone(syncDone), .syncHold(syncHold),
    .busReqIn(busReqIn), .iBrk2In(iBrk2In), .dBrk2In(dBrk2In), .quiesceReq(quiesceReq),
    .snoopEn(snoopEn), .quiescent(quiescent), .reservation(reservation),
    .timeBase(timeBase), .execStall(execStall), .outputsValid(outputsValid),
    .bus_request_out(busOut), .instr_breakpoint2_hit_out(iOut),
    .data_breakpoint2_hit_out(dOut));
  csq_sys_model #(.ACK_WAIT(2)) sys_u (.clk(clk), .rst_b(rst_b),
    .quiesceReq(quiesceReq), .ackAllowed(ackAllowed), .quiesceAck(quiesceAck));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic give_up(input bit ok);
    if (!ok) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic reset_valid();
    rst_b = 1'b1;
    {busReqIn, iBrk2In, dBrk2In} = 3'h5;
    step(2);
    `CHK(outputsValid, 1'b0)
    `CHK({busOut, iOut, dOut}, 3'h5)
    {busReqIn, iBrk2In, dBrk2In} = 3'h0;
    step();
    `CHK(outputsValid, 1'b1)
  endtask
  task automatic quiesce_seq();
    int i;
    quiesceWant = 1'b1;
    for (i = 0; i < 10 && quiesceReq !== 1'b1; i++) step();
    give_up(i < 10);
    step(8);
    `CHK({quiescent, snoopEn}, 2'h1)
    ackAllowed = 1'b1;
    for (i = 0; i < 12 && quiescent !== 1'b1; i++) step();
    give_up(i < 12);
    `CHK(snoopEn, 1'b0)
    step(5);
    `CHK({quiesceReq, quiescent}, 2'h3)
    quiesceWant = 1'b0;
    for (i = 0; i < 10 && quiescent !== 1'b0; i++) step();
    give_up(i < 10);
    `CHK({quiesceReq, snoopEn}, 2'h1)
    ackAllowed = 1'b0;
    step(3);
  endtask
  task automatic quiesce_abort();
    int i;
    quiesceWant = 1'b1;
    for (i = 0; i < 10 && quiesceReq !== 1'b1; i++) step();
    give_up(i < 10);
    step(2);
    quiesceWant = 1'b0;
    for (i = 0; i < 10 && quiesceReq !== 1'b0; i++) step();
    give_up(i < 10);
    `CHK({quiescent, snoopEn}, 2'h1)
    step(3);
    `CHK({quiesceReq, quiescent}, 2'h0)
  endtask
  task automatic resv_seq();
    loadReserve = 1'b1;
    step();
    loadReserve = 1'b0;
    `CHK(reservation, 1'b1)
    resvClear = 1'b1;
    step();
    `CHK(reservation, 1'b0)
    loadReserve = 1'b1;
    step();
    {loadReserve, resvClear} = 2'h0;
    `CHK(reservation, 1'b1)
  endtask
  task automatic tb_seq();
    logic [63:0] t0;
    timeBaseEn = 1'b1;
    step(4);
    t0 = timeBase;
    step(5);
    `CHK(timeBase, t0 + 64'h5)
    timeBaseEn = 1'b0;
    step(4);
    t0 = timeBase;
    step(5);
    `CHK(timeBase, t0)
  endtask
  task automatic sync_seq();
    int i;
    syncDone = 1'b1;
    step();
    `CHK(execStall, 1'b0)
    {syncHold, syncDone} = 2'h2;
    step(3);
    syncDone = 1'b1;
    step();
    syncDone = 1'b0;
    step(3);
    `CHK(execStall, 1'b1)
    syncHold = 1'b0;
    for (i = 0; i < 6 && execStall !== 1'b0; i++) step();
    give_up(i < 6);
  endtask
  task automatic pass_seq();
    logic [2:0] v;
    for (int k = 1; k < 8; k++) begin
      v = k[2:0];
      {busReqIn, iBrk2In, dBrk2In} = v;
      step();
      `CHK({busOut, iOut, dOut}, v)
    end
    `CHK(outputsValid, 1'b1)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    comparisons = 0;
    {rst_b, quiesceWant, loadReserve, resvClear, timeBaseEn, syncDone} = 6'h0;
    {syncHold, busReqIn, iBrk2In, dBrk2In, ackAllowed} = 5'h0;
    step(6);
    reset_valid();
    quiesce_seq();
    quiesce_abort();
    resv_seq();
    tb_seq();
    sync_seq();
    pass_seq();
    end_sim();
  end
endmodule
